// ==== ocd_bitunit.sv ====
// Bit operations: single bit write, order reverse, bit test, zero and sign.
module ocd_bitunit (
  // Operands
  input wire logic [7:0] val_i,
  input wire logic [2:0] bit_i,
  input wire logic pol_i,
  input wire logic rev_i,
  // Results
  output logic [7:0] res_o,
  output logic match_o,
  output logic zero_o,
  output logic sign_o
);
  logic [7:0] rev;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rev
      assign rev[g] = val_i[7 - g];
    end
  endgenerate
  always_comb begin
    res_o = val_i;
    if (rev_i) begin
      res_o = rev;
    end else begin
      res_o[bit_i] = pol_i;
    end
  end
  assign match_o = (val_i[bit_i] == pol_i);
  assign zero_o = (res_o == 8'h00);
  assign sign_o = res_o[7];
endmodule : ocd_bitunit

// ==== ocd_consts.svh ====
// Opcode values, guard window count and flag effect codes for the opcode decoder subset.
`ifndef OCD_CONSTS_SVH
`define OCD_CONSTS_SVH
`define OCD_OP_BRK 8'h00
`define OCD_OP_ATM 8'h2f
`define OCD_OP_PREFIX 8'h1f
`define OCD_OP_WORDX 8'he8
`define OCD_OP_BITOP 8'he2
`define OCD_OP_REV 8'hd5
`define OCD_OP_TJ_R 8'hf6
`define OCD_OP_TJ_IR 8'hf7
`define OCD_OP_JR 8'h8b
`define OCD_LO_JRCC 4'hb
`define OCD_LO_LDIM 4'hc
`define OCD_GUARD_COUNT 2'd3
`define OCD_FX_KEEP 3'd0
`define OCD_FX_RESULT 3'd1
`define OCD_FX_UNDEF 3'd2
`define OCD_FX_ZERO 3'd3
`define OCD_FX_ONE 3'd4
`endif

// ==== ocd_decoder.sv ====
// Opcode decoder top: fetch and execute sequencing, guard window and outputs.
`include "ocd_consts.svh"
module ocd_decoder (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Fetch stream
  input wire logic OP_VALID_I,
  input wire logic [7:0] OP_BYTE_I,
  output logic OP_READY_O,
  // Operand and program counter
  input wire logic [7:0] OPERAND_I,
  input wire logic [2:0] BIT_SEL_I,
  input wire logic POLARITY_I,
  input wire logic COND_TRUE_I,
  input wire logic [15:0] PC_I,
  // Decoded instruction
  output ocd_pkg::ocd_info_t INFO_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [15:0] PC_NEXT_O,
  // Results
  output logic [7:0] RESULT_O,
  output logic RES_ZERO_O,
  output logic RES_SIGN_O,
  output logic JUMP_TAKEN_O,
  output logic AUTOINC_O,
  output logic DEBUG_BREAK_O,
  output logic IRQ_BLOCK_O
);
  ocd_pkg::ocd_state_t state_r;
  ocd_pkg::ocd_info_t info;
  ocd_pkg::ocd_info_t info_r;
  logic prefix_r;
  logic [3:0] cnt_r;
  logic [1:0] guard_r;
  logic [7:0] res;
  logic match;
  logic zero;
  logic sign;
  logic accept;
  logic last_exec;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  ocd_table u_table (
    .op_i(OP_BYTE_I),
    .prefixed_i(prefix_r),
    .info_o(info)
  );

  ocd_bitunit u_bit (
    .val_i(OPERAND_I),
    .bit_i(BIT_SEL_I),
    .pol_i(POLARITY_I),
    .rev_i(info_r.cls == ocd_pkg::OCD_C_REVERSE),
    .res_o(res),
    .match_o(match),
    .zero_o(zero),
    .sign_o(sign)
  );

  // ****************************************************************
  // Handshake
  // ****************************************************************
  assign OP_READY_O = (state_r == ocd_pkg::OCD_IDLE);
  assign accept = OP_VALID_I && OP_READY_O;
  assign last_exec = (state_r == ocd_pkg::OCD_EXEC) && (cnt_r == 4'd1);
  assign BUSY_O = !OP_READY_O;

  // ****************************************************************
  // Prefix and sequencer
  // ****************************************************************
  // A prefix byte is remembered so the next byte decodes from the second page.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      prefix_r <= 1'b0;
    end else if (accept) begin
      prefix_r <= !prefix_r && (OP_BYTE_I == `OCD_OP_PREFIX);
    end
  end

  // Sequencer: fetch cycles first, then execution cycles.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_r <= ocd_pkg::OCD_IDLE;
      cnt_r <= 4'd0;
      info_r <= '0;
    end else begin
      case (state_r)
        ocd_pkg::OCD_IDLE: begin
          if (accept && info.valid) begin
            info_r <= info;
            if (info.fetch > 3'd1) begin
              state_r <= ocd_pkg::OCD_FETCH;
              cnt_r <= {1'b0, info.fetch} - 4'd1;
            end else begin
              state_r <= ocd_pkg::OCD_EXEC;
              cnt_r <= info.exec;
            end
          end
        end
        ocd_pkg::OCD_FETCH: begin
          if (cnt_r == 4'd1) begin
            state_r <= ocd_pkg::OCD_EXEC;
            cnt_r <= info_r.exec;
          end else begin
            cnt_r <= cnt_r - 4'd1;
          end
        end
        ocd_pkg::OCD_EXEC: begin
          if (cnt_r == 4'd1) begin
            state_r <= ocd_pkg::OCD_IDLE;
            cnt_r <= 4'd0;
          end else begin
            cnt_r <= cnt_r - 4'd1;
          end
        end
        default: begin
          state_r <= ocd_pkg::OCD_IDLE;
          cnt_r <= 4'd0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************
  // program counter advance
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PC_NEXT_O <= 16'h0000;
    end else if (accept && info.valid) begin
      PC_NEXT_O <= PC_I + {13'h0000, info.fetch};
    end
  end

  // ****************************************************************
  // Guard window
  // ****************************************************************
  // guard countdown
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      guard_r <= 2'd0;
    end else if (last_exec) begin
      if (info_r.cls == ocd_pkg::OCD_C_GUARD) begin
        guard_r <= `OCD_GUARD_COUNT;
      end else if (guard_r != 2'd0) begin
        guard_r <= guard_r - 2'd1;
      end
    end
  end
  assign IRQ_BLOCK_O = (guard_r != 2'd0) ||
                       (state_r != ocd_pkg::OCD_IDLE && info_r.cls == ocd_pkg::OCD_C_GUARD);

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Results are registered at the final execution cycle.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      DONE_O <= 1'b0;
      INFO_O <= '0;
      RESULT_O <= 8'h00;
      RES_ZERO_O <= 1'b0;
      RES_SIGN_O <= 1'b0;
      JUMP_TAKEN_O <= 1'b0;
      AUTOINC_O <= 1'b0;
      DEBUG_BREAK_O <= 1'b0;
    end else begin
      DONE_O <= last_exec;
      DEBUG_BREAK_O <= last_exec && info_r.cls == ocd_pkg::OCD_C_BREAK;
      AUTOINC_O <= last_exec && info_r.autoinc;
      if (last_exec) begin
        INFO_O <= info_r;
        RESULT_O <= res;
        RES_ZERO_O <= zero;
        RES_SIGN_O <= sign;
      end
      JUMP_TAKEN_O <= last_exec && (
        (info_r.cls == ocd_pkg::OCD_C_TESTJ && match) ||
        (info_r.cls == ocd_pkg::OCD_C_RJUMP && (!info_r.cond_jump || COND_TRUE_I)));
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_guard_done;
    last_exec && info_r.cls == ocd_pkg::OCD_C_GUARD;
  endsequence

  a_guard_block: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s_guard_done |=> guard_r == 2'd3 && IRQ_BLOCK_O)
    else $error("guard window not opened");

  a_and_cycles: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'h58 |-> info.fetch == 3'd4 && info.exec == 4'd3)
    else $error("extended and cycles wrong");

  a_bitop_flags: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'he2 |-> info.flags.v == ocd_pkg::OCD_ZERO)
    else $error("bit write must clear overflow");

  a_break_pulse: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'h00 |-> ##2 DEBUG_BREAK_O)
    else $error("break not signalled");

  a_rev_carry: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'hd5 |-> info.flags.c == ocd_pkg::OCD_UNDEF)
    else $error("reverse carry not undefined");

  a_tj_cycles: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'hf7 |-> ##7 DONE_O)
    else $error("test jump timing wrong");

  a_jr_always: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'h8b |-> ##4 JUMP_TAKEN_O)
    else $error("unconditional jump not taken");

  a_word_move: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && prefix_r && OP_BYTE_I == 8'he8 |-> ##9 DONE_O)
    else $error("word move timing wrong");

  a_pc_advance: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && info.valid |=> PC_NEXT_O == $past(PC_I) + {13'h0000, $past(info.fetch)})
    else $error("program counter not advanced");

  sequence s_guard_step;
    last_exec && guard_r != 2'd0 && info_r.cls != ocd_pkg::OCD_C_GUARD;
  endsequence

  sequence s_bitop_last;
    last_exec && info_r.cls == ocd_pkg::OCD_C_BITOP;
  endsequence

  sequence s_rev_last;
    last_exec && info_r.cls == ocd_pkg::OCD_C_REVERSE;
  endsequence

  sequence s_testj_last;
    last_exec && info_r.cls == ocd_pkg::OCD_C_TESTJ;
  endsequence

  sequence s_rjump_last;
    last_exec && info_r.cls == ocd_pkg::OCD_C_RJUMP && info_r.cond_jump;
  endsequence

  a_reset_idle: assert property (@(posedge CLK_I)
    SYS_RST_I |=> OP_READY_O && !DONE_O && !IRQ_BLOCK_O)
    else $error("decoder not idle after reset");

  a_done_pulse: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    DONE_O |=> !DONE_O)
    else $error("completion pulse longer than one cycle");

  a_pc_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !OP_READY_O |=> $stable(PC_NEXT_O))
    else $error("program counter moved while busy");

  a_guard_keep: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'h2f |-> info.flags == '0 && info.exec == 4'd2)
    else $error("guard must keep flags");

  a_guard_step: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s_guard_step |=> guard_r == $past(guard_r) - 2'd1)
    else $error("guard window did not count down");

  a_and_flags: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I inside {[8'h52:8'h59]} |->
      info.flags.z == ocd_pkg::OCD_RESULT && info.flags.v == ocd_pkg::OCD_ZERO)
    else $error("and flag effects wrong");

  a_bit_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s_bitop_last |=> RESULT_O[$past(BIT_SEL_I)] == $past(POLARITY_I) &&
      RES_ZERO_O == (RESULT_O == 8'h00))
    else $error("bit write result wrong");

  a_rev_result: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s_rev_last |=> RESULT_O[0] == $past(OPERAND_I[7]) && RESULT_O[7] == $past(OPERAND_I[0]))
    else $error("reverse result wrong");

  a_tj_match: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s_testj_last |=> JUMP_TAKEN_O == ($past(OPERAND_I[BIT_SEL_I]) == $past(POLARITY_I)))
    else $error("test jump decision wrong");

  a_tj_fetch: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'hf6 |-> info.fetch == 3'd3 && info.exec == 4'd3)
    else $error("test jump cycle counts wrong");

  a_jr_cond: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s_rjump_last |=> JUMP_TAKEN_O == $past(COND_TRUE_I))
    else $error("conditional jump decision wrong");

  a_move_keep: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && info.valid && info.cls == ocd_pkg::OCD_C_MOVE |-> info.flags == '0)
    else $error("register move must keep flags");

  a_code_cycles: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'hc5 |-> ##11 DONE_O)
    else $error("code load timing wrong");

  a_codei_pulse: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'hd3 |-> ##11 (DONE_O && AUTOINC_O))
    else $error("code increment pulse missing");

  a_data_cycles: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'h92 |-> ##7 DONE_O)
    else $error("data store timing wrong");

  a_datai_pulse: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && !prefix_r && OP_BYTE_I == 8'h83 |-> ##11 (DONE_O && AUTOINC_O))
    else $error("data increment pulse missing");

  a_word_keep: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    accept && prefix_r && OP_BYTE_I == 8'he8 |->
      info.flags == '0 && info.cls == ocd_pkg::OCD_C_WORDX)
    else $error("word move decode wrong");

  a_rev_fx: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    DONE_O && INFO_O.cls == ocd_pkg::OCD_C_REVERSE |->
      INFO_O.flags.c == ocd_pkg::OCD_UNDEF && INFO_O.flags.v == ocd_pkg::OCD_ZERO)
    else $error("reverse flag effects wrong");
endmodule : ocd_decoder

// ==== ocd_fetch_model.sv ====
// Fetch stream model that offers opcode bytes to the decoder.
module ocd_fetch_model (
  // Clock
  input wire logic clk_i,
  // Handshake
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Offers that never saw ready; the bench counts any nonzero total as one mismatch.
  int stalls = 0;

  initial begin
    valid_o = 1'b0;
    byte_o = 8'h00;
  end

  // ************************************************************
  // Byte offer
  // ************************************************************
  // The byte is held until an edge sees ready high, or until 50 cycles pass without it. Once released, the
  // line shows the inverse, so a stale byte can never pass for a fresh one.
  task automatic send(input logic [7:0] b);
    int k;
    @(negedge clk_i);
    valid_o = 1'b1;
    byte_o = b;
    k = 0;
    while (ready_i !== 1'b1 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 50) stalls++;
    @(posedge clk_i);
    @(negedge clk_i);
    valid_o = 1'b0;
    byte_o = ~b;
  endtask : send
endmodule : ocd_fetch_model

// ==== ocd_pkg.sv ====
// Types shared by the opcode decoder files.
package ocd_pkg;
  typedef enum logic [2:0] {
    OCD_KEEP = 3'h0,
    OCD_RESULT = 3'h1,
    OCD_UNDEF = 3'h2,
    OCD_ZERO = 3'h3,
    OCD_ONE = 3'h4
  } ocd_fx_t;
  typedef enum logic [3:0] {
    OCD_C_NONE, OCD_C_AND, OCD_C_EXTENDED_CONJUNCTION, OCD_C_GUARD, OCD_C_BITOP, OCD_C_BREAK,
    OCD_C_REVERSE, OCD_C_TESTJ, OCD_C_RJUMP, OCD_C_MOVE, OCD_C_CODE, OCD_C_CODEI,
    OCD_C_DATA, OCD_C_DATAI, OCD_C_WORDX
  } ocd_class_t;
  typedef struct packed {
    ocd_fx_t c;
    ocd_fx_t z;
    ocd_fx_t s;
    ocd_fx_t v;
    ocd_fx_t d;
    ocd_fx_t h;
  } ocd_flags_t;
  typedef struct packed {
    logic valid;
    ocd_class_t cls;
    logic [7:0] opcode;
    logic [3:0] dst_mode;
    logic [3:0] src_mode;
    logic [2:0] fetch;
    logic [3:0] exec;
    ocd_flags_t flags;
    logic autoinc;
    logic cond_jump;
  } ocd_info_t;
  typedef enum logic [1:0] {
    OCD_IDLE = 2'b00,
    OCD_FETCH = 2'b01,
    OCD_EXEC = 2'b11
  } ocd_state_t;
endpackage : ocd_pkg

// ==== ocd_table.sv ====
// Combinational opcode table: class, cycles, addressing and flag effects.
`include "ocd_consts.svh"
module ocd_table (
  // Opcode
  input wire logic [7:0] op_i,
  input wire logic prefixed_i,
  // Decoded
  output ocd_pkg::ocd_info_t info_o
);
  function automatic ocd_pkg::ocd_flags_t fl(input ocd_pkg::ocd_fx_t c,
                                             input ocd_pkg::ocd_fx_t zs,
                                             input ocd_pkg::ocd_fx_t v);
    fl = '{c: c, z: zs, s: zs, v: v, d: ocd_pkg::OCD_KEEP, h: ocd_pkg::OCD_KEEP};
  endfunction : fl

  function automatic ocd_pkg::ocd_info_t mk(input ocd_pkg::ocd_class_t cls,
                                            input logic [2:0] f, input logic [3:0] e);
    mk = '0;
    mk.valid = 1'b1;
    mk.cls = cls;
    mk.fetch = f;
    mk.exec = e;
    mk.flags = fl(ocd_pkg::OCD_KEEP, ocd_pkg::OCD_KEEP, ocd_pkg::OCD_KEEP);
  endfunction : mk

  always_comb begin
    info_o = '0;
    if (prefixed_i && op_i == `OCD_OP_WORDX) begin
      info_o = mk(ocd_pkg::OCD_C_WORDX, 3'd5, 4'd4);
    end else if (!prefixed_i) begin
      case (op_i)
        `OCD_OP_BRK: info_o = mk(ocd_pkg::OCD_C_BREAK, 3'd1, 4'd1);
        `OCD_OP_ATM: info_o = mk(ocd_pkg::OCD_C_GUARD, 3'd1, 4'd2);
        8'h52, 8'h58, 8'h59, 8'h54, 8'h56: begin
          info_o = mk(ocd_pkg::OCD_C_AND, (op_i[3]) ? 3'd4 : ((op_i == 8'h52) ? 3'd2 : 3'd3),
                      4'd3);
        end
        8'h53, 8'h55, 8'h57: begin
          info_o = mk(ocd_pkg::OCD_C_AND, (op_i == 8'h53) ? 3'd2 : 3'd3, 4'd4);
        end
        `OCD_OP_BITOP: info_o = mk(ocd_pkg::OCD_C_BITOP, 3'd2, 4'd2);
        `OCD_OP_REV: info_o = mk(ocd_pkg::OCD_C_REVERSE, 3'd2, 4'd2);
        `OCD_OP_TJ_R: info_o = mk(ocd_pkg::OCD_C_TESTJ, 3'd3, 4'd3);
        `OCD_OP_TJ_IR: info_o = mk(ocd_pkg::OCD_C_TESTJ, 3'd3, 4'd4);
        8'hc7, 8'he5, 8'hf5, 8'he7, 8'hd7, 8'he4, 8'he6: begin
          info_o = mk(ocd_pkg::OCD_C_MOVE, 3'd3,
                      (op_i == 8'hd7 || op_i == 8'he5) ? 4'd4 :
                      ((op_i == 8'he4 || op_i == 8'he6) ? 4'd2 : 4'd3));
        end
        8'he3, 8'hf3: info_o = mk(ocd_pkg::OCD_C_MOVE, 3'd2, 4'd3);
        8'hc2, 8'hd2: info_o = mk(ocd_pkg::OCD_C_CODE, 3'd2, 4'd5);
        8'hc5: info_o = mk(ocd_pkg::OCD_C_CODE, 3'd2, 4'd9);
        8'hc3, 8'hd3: info_o = mk(ocd_pkg::OCD_C_CODEI, 3'd2, 4'd9);
        8'h82, 8'h92: info_o = mk(ocd_pkg::OCD_C_DATA, 3'd2, 4'd5);
        8'h83, 8'h93: info_o = mk(ocd_pkg::OCD_C_DATAI, 3'd2, 4'd9);
        default: begin
          if (op_i[3:0] == `OCD_LO_JRCC) begin
            info_o = mk(ocd_pkg::OCD_C_RJUMP, 3'd2, 4'd2);
            info_o.cond_jump = (op_i != `OCD_OP_JR);
          end else if (op_i[3:0] == `OCD_LO_LDIM) begin
            info_o = mk(ocd_pkg::OCD_C_MOVE, 3'd2, 4'd2);
          end
        end
      endcase
      case (info_o.cls)
        ocd_pkg::OCD_C_AND, ocd_pkg::OCD_C_BITOP:
          info_o.flags = fl(ocd_pkg::OCD_KEEP, ocd_pkg::OCD_RESULT, ocd_pkg::OCD_ZERO);
        ocd_pkg::OCD_C_REVERSE:
          info_o.flags = fl(ocd_pkg::OCD_UNDEF, ocd_pkg::OCD_RESULT, ocd_pkg::OCD_ZERO);
        default: info_o.flags = info_o.flags;
      endcase
      info_o.autoinc = (info_o.cls == ocd_pkg::OCD_C_CODEI) ||
                       (info_o.cls == ocd_pkg::OCD_C_DATAI);
      info_o.opcode = op_i;
      info_o.dst_mode = op_i[7:4];
      info_o.src_mode = op_i[3:0];
    end
  end
endmodule : ocd_table

// ==== test_ocd_decoder.sv ====
// Self-checking testbench for the opcode decoder.
module test_ocd_decoder;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid;
  logic [7:0] op_byte;
  logic op_ready;
  logic [7:0] operand = 8'h00;
  logic [2:0] bit_sel = 3'd0;
  logic pol = 1'b0;
  logic cond = 1'b0;
  logic [15:0] pc = 16'h0000;
  ocd_pkg::ocd_info_t info;
  logic busy, done, zero, sign, jump, autoinc, debug_halt_op, irq_block, blk_seen;
  logic [15:0] pc_next;
  logic [7:0] result;
  int failures = 0;
  int samples_checked = 0;
  logic [7:0] ops [35] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h2f,
    8'he2, 8'h00, 8'hd5, 8'hf6, 8'hf7, 8'h8b, 8'h1b, 8'h0c, 8'hc7, 8'hd7, 8'he3, 8'he4,
    8'he5, 8'he6, 8'he7, 8'hf3, 8'hf5, 8'hc2, 8'hc5, 8'hd2, 8'hc3, 8'hd3, 8'h82, 8'h92,
    8'h83, 8'h93};
  // Upper nibble is the fetch count, lower nibble the execution count.
  logic [7:0] fe [35] = '{8'h23, 8'h24, 8'h33, 8'h34, 8'h33, 8'h34, 8'h43, 8'h43, 8'h12,
    8'h22, 8'h11, 8'h22, 8'h33, 8'h34, 8'h22, 8'h22, 8'h22, 8'h33, 8'h34, 8'h23, 8'h32,
    8'h34, 8'h32, 8'h33, 8'h23, 8'h33, 8'h25, 8'h29, 8'h25, 8'h29, 8'h29, 8'h25, 8'h25,
    8'h29, 8'h29};

  always #10 clk = ~clk;

  ocd_fetch_model ocd_fetch_model_inst (.clk_i(clk), .ready_i(op_ready), .valid_o(op_valid),
    .byte_o(op_byte));
  ocd_decoder ocd_decoder_inst (.CLK_I(clk), .SYS_RST_I(rst), .OP_VALID_I(op_valid),
    .OP_BYTE_I(op_byte), .OP_READY_O(op_ready), .OPERAND_I(operand), .BIT_SEL_I(bit_sel),
    .POLARITY_I(pol), .COND_TRUE_I(cond), .PC_I(pc), .INFO_O(info), .BUSY_O(busy),
    .DONE_O(done), .PC_NEXT_O(pc_next), .RESULT_O(result), .RES_ZERO_O(zero),
    .RES_SIGN_O(sign), .JUMP_TAKEN_O(jump), .AUTOINC_O(autoinc), .DEBUG_BREAK_O(debug_halt_op),
    .IRQ_BLOCK_O(irq_block));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic ocd_pkg::ocd_flags_t exp_fx(input logic [7:0] op);
    ocd_pkg::ocd_flags_t f;
    f = '{default: ocd_pkg::OCD_KEEP};
    if (op inside {[8'h52:8'h59], 8'he2, 8'hd5}) begin
      f.z = ocd_pkg::OCD_RESULT;
      f.s = ocd_pkg::OCD_RESULT;
      f.v = ocd_pkg::OCD_ZERO;
    end
    if (op == 8'hd5) begin
      f.c = ocd_pkg::OCD_UNDEF;
    end
    return f;
  endfunction : exp_fx

  // Counts edges from the accepting edge to the completion pulse.
  task automatic run(input logic [7:0] op, input int f, input int e);
    int n;
    logic jx;
    pc = {8'h40, op};
    jx = op == 8'h8b || (op[3:0] == 4'hb && cond);
    jx = jx || (op inside {8'hf6, 8'hf7} && operand[bit_sel] == pol);
    ocd_fetch_model_inst.send(op);
    blk_seen = irq_block;
    chk(busy, 1'b1);
    n = 1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
      @(negedge clk);
      if (n == 2) chk(pc_next, 16'(pc + f));
    end
    chk(busy, 1'b0);
    chk(info.fetch, f);
    chk(info.exec, e);
    chk(n, f + e);
    chk(info.flags, exp_fx(op));
    chk(jump, jx);
    chk(autoinc, op inside {8'hc3, 8'hd3, 8'h83, 8'h93});
    chk(debug_halt_op, op == 8'h00);
  endtask : run

  task automatic no_done();
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(negedge clk);
      if (done === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b0);
  endtask : no_done

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_table();
    operand = 8'h5a;
    bit_sel = 3'd1;
    pol = 1'b1;
    // every listed opcode back to back.
    for (int i = 0; i < 35; i++) run(ops[i], int'(fe[i][7:4]), int'(fe[i][3:0]));
    $display("table test done");
  endtask : t_table

  task automatic bitcase(input logic [7:0] op, input logic [7:0] v, input logic [2:0] b,
                         input logic p, input logic [7:0] r);
    operand = v;
    bit_sel = b;
    pol = p;
    run(op, 2, 2);
    chk(result, r);
    chk(zero, r == 8'h00);
    chk(sign, r[7]);
  endtask : bitcase

  task automatic t_bits();
    bitcase(8'he2, 8'h80, 3'd0, 1'b1, 8'h81);
    bitcase(8'he2, 8'h80, 3'd7, 1'b0, 8'h00);
    bitcase(8'hd5, 8'h01, 3'd0, 1'b0, 8'h80);
    bitcase(8'hd5, 8'h35, 3'd0, 1'b0, 8'hac);
    operand = 8'h5a;
    bit_sel = 3'd1;
    pol = 1'b0;
    run(8'hf6, 3, 3);
    run(8'hf7, 3, 4);
    cond = 1'b1;
    run(8'h1b, 2, 2);
    cond = 1'b0;
    $display("bit test done");
  endtask : t_bits

  task automatic t_guard();
    run(8'h2f, 1, 2);
    chk(blk_seen, 1'b1);
    for (int k = 0; k < 4; k++) begin
      run(8'h00, 1, 1);
      chk(blk_seen, k < 3);
    end
    $display("guard test done");
  endtask : t_guard

  task automatic t_word();
    ocd_fetch_model_inst.send(8'h1f);
    run(8'he8, 5, 4);
    chk(info.cls, ocd_pkg::OCD_C_WORDX);
    ocd_fetch_model_inst.send(8'h1f);
    ocd_fetch_model_inst.send(8'h52);
    no_done();
    ocd_fetch_model_inst.send(8'h01);
    no_done();
    run(8'h00, 1, 1);
    $display("word test done");
  endtask : t_word

  // ************************************************************
  // Sequence and verdict
  // ************************************************************
  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (6) @(negedge clk);
    chk(op_ready, 1'b1);
    chk(done, 1'b0);
    rst = 1'b0;
    t_table();
    t_bits();
    t_guard();
    t_word();
    chk(ocd_fetch_model_inst.stalls, 0);
    results();
  end

  initial begin
    #(20 * 5000);
    failures++;
    results();
  end
endmodule : test_ocd_decoder
